// ---- hbgd_pkg.sv ----
// Package for the half-bridge gate drive sequencer
`default_nettype none
package hbgd_pkg;
	// Widths and default counts
	localparam int unsigned HBGD_TMR_W          = 16;
	localparam int unsigned HBGD_CLK_MHZ        = 250;
	localparam int unsigned HBGD_DRIVE_NS       = 4000;
	localparam logic [15:0] HBGD_DRIVE_CYC_RST  = 16'(HBGD_DRIVE_NS * HBGD_CLK_MHZ / 1000);
	localparam logic [7:0]  HBGD_CMP_CFG_RST    = 8'h00;

	// Stage drive for one gate
	typedef struct packed {
		logic strong_src;
		logic hold_src;
		logic strong_pd;
		logic weak_pd;
	} hbgd_drive_s;

	// Comparator results for one gate
	typedef struct packed {
		logic vgs_high;
		logic vds_over;
	} hbgd_mon_s;

	// Per-gate drive phases
	typedef enum logic [2:0] {
		HBGD_OFF,
		HBGD_WAIT,
		HBGD_STRONG,
		HBGD_HOLD,
		HBGD_FAULT
	} hbgd_state_e;
endpackage : hbgd_pkg
`default_nettype wire

// ---- hbgd_sync.sv ----
// Two-flop synchroniser for a bus of pin inputs
`default_nettype none
module hbgd_sync #(
	parameter int unsigned W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [W-1:0] meta;

	// Two stages, first read only by the second
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta <= '0;
			q    <= '0;
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : hbgd_sync
`default_nettype wire

// ---- hbgd_sequencer.sv ----
// Half-bridge gate drive sequencer top
//
// Behaviour
// - Turn on a switch only after the opposite gate monitor reads off.
// - Handshake both directions; dead time follows monitor feedback.
// - On turn-on command apply strong source and start drive timer.
// - Gate not risen at timer expiry: flag fault and disable gate.
// - Timer expiry without fault: switch to small holding current.
// - Keep strong low-side pulldown while high-side drain-source slews.
// - After switching period drop strong pulldown, keep weak pulldown.
// - Each gate has drain-source and gate-source comparators for faults.
// - Comparator settings from serial config or hardwired pins, selectable.
`default_nettype none
module hbgd_sequencer
	import hbgd_pkg::*;
#(
	parameter logic [HBGD_TMR_W-1:0] DRIVE_CYC = HBGD_DRIVE_CYC_RST
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rstn,
	// Commands (pins)
	input  wire logic                  cmd_hs,
	input  wire logic                  cmd_ls,
	input  wire logic                  fault_clear,
	// Drive timer setting
	input  wire logic [HBGD_TMR_W-1:0] strong_drive_timer,
	input  wire logic                  timer_use_cfg,
	// Comparator configuration sources
	input  wire logic [7:0]            cmp_cfg_serial,
	input  wire logic [7:0]            cmp_cfg_pins,
	input  wire logic                  cmp_cfg_sel_serial,
	// Monitors (pins) and slew indication
	input  wire hbgd_mon_s             mon_hs,
	input  wire hbgd_mon_s             mon_ls,
	input  wire logic                  hs_vds_slewing,
	// Gate stage drive
	output hbgd_drive_s                drv_hs,
	output hbgd_drive_s                drv_ls,
	// Status
	output logic                       gate_fault_hs,
	output logic                       gate_fault_ls,
	output logic                       overcurrent_hs,
	output logic                       overcurrent_ls,
	output logic [7:0]                 cmp_cfg
);
	timeunit 1ns;
	timeprecision 1ps;
	// Synchronised pin inputs
	localparam int unsigned NSYNC = 8;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] syn_in;
	assign raw_in = {cmd_hs, cmd_ls, fault_clear, mon_hs, mon_ls, hs_vds_slewing};

	hbgd_sync #(.W(NSYNC)) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.d    (raw_in),
		.q    (syn_in)
	);

	logic      s_cmd [2];
	logic      s_clr;
	hbgd_mon_s s_mon [2];
	logic      s_slew;
	assign s_cmd[1] = syn_in[7];
	assign s_cmd[0] = syn_in[6];
	assign s_clr    = syn_in[5];
	assign s_mon[1] = syn_in[4:3];
	assign s_mon[0] = syn_in[2:1];
	assign s_slew   = syn_in[0];

	// Effective drive timer length, never zero
	logic [HBGD_TMR_W-1:0] tmr_len;
	assign tmr_len = (timer_use_cfg && strong_drive_timer != '0) ? strong_drive_timer : DRIVE_CYC;

	// Per-gate state, index 1 high side, 0 low side
	hbgd_state_e           state      [2];
	hbgd_state_e           next_state [2];
	logic [HBGD_TMR_W-1:0] tmr        [2];
	logic [HBGD_TMR_W-1:0] next_tmr   [2];
	logic                  flt        [2];
	logic                  next_flt   [2];
	hbgd_drive_s           drv        [2];
	hbgd_drive_s           next_drv   [2];
	logic                  oc         [2];
	logic                  next_oc    [2];

	// Strong low-side pulldown window while high side slews
	logic pd_hold;
	logic next_pd_hold;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_gate
			// Next-state logic for one gate
			always_comb
			begin
				next_state[g] = state[g];
				next_tmr[g]   = tmr[g];
				next_flt[g]   = flt[g];
				next_oc[g]    = s_mon[g].vds_over & (state[g] == HBGD_HOLD);
				case (state[g])
					HBGD_OFF:
					begin
						if (s_cmd[g] && !s_cmd[1-g] && !flt[g])
							next_state[g] = HBGD_WAIT;
					end
					HBGD_WAIT:
					begin
						if (!s_cmd[g])
							next_state[g] = HBGD_OFF;
						else if (state[1-g] == HBGD_OFF && !s_mon[1-g].vgs_high)
						begin
							next_state[g] = HBGD_STRONG;
							next_tmr[g]   = tmr_len;
						end
					end
					HBGD_STRONG:
					begin
						if (!s_cmd[g])
							next_state[g] = HBGD_OFF;
						else if (tmr[g] > 16'h0001)
							next_tmr[g] = tmr[g] - 16'h0001;
						else if (!s_mon[g].vgs_high)
						begin
							next_state[g] = HBGD_FAULT;
							next_flt[g]   = 1'b1;
						end
						else
							next_state[g] = HBGD_HOLD;
					end
					HBGD_HOLD:
					begin
						if (!s_cmd[g])
							next_state[g] = HBGD_OFF;
					end
					HBGD_FAULT:
					begin
						if (s_clr)
						begin
							next_state[g] = HBGD_OFF;
							next_flt[g]   = 1'b0;
						end
					end
					default:
						next_state[g] = HBGD_OFF;
				endcase
			end

			// Stage outputs from next state
			always_comb
			begin
				next_drv[g]            = '0;
				next_drv[g].strong_src = (next_state[g] == HBGD_STRONG);
				next_drv[g].hold_src   = (next_state[g] == HBGD_HOLD);
				next_drv[g].weak_pd    = !(next_state[g] == HBGD_STRONG || next_state[g] == HBGD_HOLD);
				if (g == 0 && next_pd_hold && next_drv[g].weak_pd)
				begin
					next_drv[g].strong_pd = 1'b1;
					next_drv[g].weak_pd   = 1'b0;
				end
			end

			// Registers for one gate
			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
				begin
					state[g] <= HBGD_OFF;
					tmr[g]   <= '0;
					flt[g]   <= 1'b0;
					drv[g]   <= '0;
					oc[g]    <= 1'b0;
				end
				else
				begin
					state[g] <= next_state[g];
					tmr[g]   <= next_tmr[g];
					flt[g]   <= next_flt[g];
					drv[g]   <= next_drv[g];
					oc[g]    <= next_oc[g];
				end
			end
		end
	endgenerate

	// Strong pulldown held from high-side turn-on until slewing and the strong phase have both ended, or the high side goes off or faults
	always_comb
	begin
		next_pd_hold = pd_hold;
		if (next_state[1] == HBGD_STRONG && state[1] != HBGD_STRONG)
			next_pd_hold = 1'b1;
		else if (pd_hold && !s_slew && state[1] != HBGD_STRONG)
			next_pd_hold = 1'b0;
		else if (next_state[1] == HBGD_OFF || next_state[1] == HBGD_FAULT)
			next_pd_hold = 1'b0;
	end

	// Comparator configuration source select
	logic [7:0] next_cmp_cfg;
	assign next_cmp_cfg = cmp_cfg_sel_serial ? cmp_cfg_serial : cmp_cfg_pins;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pd_hold <= 1'b0;
			cmp_cfg <= HBGD_CMP_CFG_RST;
		end
		else
		begin
			pd_hold <= next_pd_hold;
			cmp_cfg <= next_cmp_cfg;
		end
	end

	// Outputs
	assign drv_hs         = drv[1];
	assign drv_ls         = drv[0];
	assign gate_fault_hs  = flt[1];
	assign gate_fault_ls  = flt[0];
	assign overcurrent_hs = oc[1];
	assign overcurrent_ls = oc[0];
endmodule : hbgd_sequencer
`default_nettype wire

// ---- hbgd_sequencer_asserts.sv ----
// Port assertions of the gate drive sequencer
`default_nettype none
module hbgd_sequencer_asserts
	import hbgd_pkg::*;
(
	// Watched ports
	input wire logic	clk,
	input wire logic	rstn,
	input wire logic	cmd_hs,
	input wire logic	cmp_cfg_sel_serial,
	input wire logic [7:0]	cmp_cfg_serial,
	input wire logic [7:0]	cmp_cfg_pins,
	input wire hbgd_drive_s	drv_hs,
	input wire hbgd_drive_s	drv_ls,
	input wire logic	gate_fault_hs,
	input wire logic	overcurrent_hs,
	input wire logic [7:0]	cmp_cfg
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Sequencing, faults, pulldowns and settings
	a_no_cross: assert property (!((drv_hs.strong_src || drv_hs.hold_src) && (drv_ls.strong_src || drv_ls.hold_src)))
		else $error("both on");
	a_hs_after_ls: assert property ($rose(drv_hs.strong_src) |-> !$past(drv_ls.hold_src))
		else $error("hs early");
	a_fault_off: assert property (gate_fault_hs |-> !drv_hs.strong_src && !drv_hs.hold_src)
		else $error("fault drive");
	// Command seen three edges back still high, so the strong phase ended on the timer
	a_hold_next: assert property ($fell(drv_hs.strong_src) && !gate_fault_hs && $past(cmd_hs, 3) |-> drv_hs.hold_src)
		else $error("no hold");
	a_ls_clamp: assert property (drv_hs.strong_src |-> drv_ls.strong_pd)
		else $error("no clamp");
	a_weak_after: assert property ($fell(drv_ls.strong_pd) && !drv_ls.strong_src |-> drv_ls.weak_pd)
		else $error("no weak");
	// Flag is registered from the phase of the cycle before
	a_oc_hold: assert property (overcurrent_hs |-> $past(drv_hs.hold_src))
		else $error("oc");
	a_cfg_sel: assert property ($stable({cmp_cfg_sel_serial, cmp_cfg_pins, cmp_cfg_serial})[*3]
		|-> cmp_cfg == (cmp_cfg_sel_serial ? cmp_cfg_serial : cmp_cfg_pins)) else $error("cfg");
	// Main scenarios reached
	c_fault: cover property ($rose(gate_fault_hs));
	c_oc: cover property ($rose(overcurrent_hs));
	c_ls_hold: cover property ($rose(drv_ls.hold_src));
endmodule : hbgd_sequencer_asserts
bind hbgd_sequencer hbgd_sequencer_asserts u_hbgd_sequencer_asserts (
	.clk                (clk),
	.rstn               (rstn),
	.cmd_hs             (cmd_hs),
	.cmp_cfg_sel_serial (cmp_cfg_sel_serial),
	.cmp_cfg_serial     (cmp_cfg_serial),
	.cmp_cfg_pins       (cmp_cfg_pins),
	.drv_hs             (drv_hs),
	.drv_ls             (drv_ls),
	.gate_fault_hs      (gate_fault_hs),
	.overcurrent_hs     (overcurrent_hs),
	.cmp_cfg            (cmp_cfg)
);
`default_nettype wire

// ---- hbgd_fet_model.sv ----
// Behavioural half-bridge switches with gate monitors
`default_nettype none
module hbgd_fet_model
	import hbgd_pkg::*;
(
	// Clock and reset
	input wire logic	clk,
	input wire logic	rstn,
	// Gate stages and injected faults
	input wire hbgd_drive_s	drv_hs,
	input wire hbgd_drive_s	drv_ls,
	input wire logic	short_hs,
	input wire logic	oc_hs,
	// Monitors
	output hbgd_mon_s	mon_hs,
	output hbgd_mon_s	mon_ls,
	output logic	hs_vds_slewing
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] gh, gl, next_gh, next_gl;
	// Gate charge delay; a shorted gate never rises
	always_comb
	begin
		next_gh = {gh[1:0], (drv_hs.strong_src | drv_hs.hold_src) & ~short_hs};
		next_gl = {gl[1:0], drv_ls.strong_src | drv_ls.hold_src};
	end
	// Gate state
	always_ff @(posedge clk or negedge rstn)
		if (!rstn) {gh, gl} <= 6'h00;
		else {gh, gl} <= {next_gh, next_gl};
	// Comparators and switch node slew
	assign mon_hs = {gh[2], oc_hs & gh[2]};
	assign mon_ls = {gl[2], 1'b0};
	assign hs_vds_slewing = gh[2] ^ gh[1];
endmodule : hbgd_fet_model
`default_nettype wire

// ---- hbgd_sequencer_test.sv ----
// Self-checking bench for the gate drive sequencer
`default_nettype none
module hbgd_sequencer_test
	import hbgd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, cmd_hs, cmd_ls, fault_clear, timer_use_cfg, cmp_cfg_sel_serial, short_hs, oc_hs, hs_vds_slewing;
	logic gate_fault_hs, gate_fault_ls, overcurrent_hs, overcurrent_ls;
	logic [15:0] strong_drive_timer;
	logic [7:0] cmp_cfg_serial, cmp_cfg_pins, cmp_cfg;
	logic [31:0] seed;
	hbgd_mon_s mon_hs, mon_ls;
	hbgd_drive_s drv_hs, drv_ls;
	int n_mismatch = 0, cmp_count = 0, i, k;
	// Design with a short strong phase, and far-side switches
	hbgd_sequencer #(.DRIVE_CYC(16'h0008)) u_hbgd_sequencer (
		.clk                (clk),
		.rstn               (rstn),
		.cmd_hs             (cmd_hs),
		.cmd_ls             (cmd_ls),
		.fault_clear        (fault_clear),
		.strong_drive_timer (strong_drive_timer),
		.timer_use_cfg      (timer_use_cfg),
		.cmp_cfg_serial     (cmp_cfg_serial),
		.cmp_cfg_pins       (cmp_cfg_pins),
		.cmp_cfg_sel_serial (cmp_cfg_sel_serial),
		.mon_hs             (mon_hs),
		.mon_ls             (mon_ls),
		.hs_vds_slewing     (hs_vds_slewing),
		.drv_hs             (drv_hs),
		.drv_ls             (drv_ls),
		.gate_fault_hs      (gate_fault_hs),
		.gate_fault_ls      (gate_fault_ls),
		.overcurrent_hs     (overcurrent_hs),
		.overcurrent_ls     (overcurrent_ls),
		.cmp_cfg            (cmp_cfg)
	);
	hbgd_fet_model u_hbgd_fet_model (
		.clk            (clk),
		.rstn           (rstn),
		.drv_hs         (drv_hs),
		.drv_ls         (drv_ls),
		.short_hs       (short_hs),
		.oc_hs          (oc_hs),
		.mon_hs         (mon_hs),
		.mon_ls         (mon_ls),
		.hs_vds_slewing (hs_vds_slewing)
	);
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) n_mismatch++;
		if (seen !== exp) $display("CHECK FAILED %0t seen=%h exp=%h", $time, seen, exp);
	endtask : chk
	task automatic end_of_test();
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	// Drop both commands, raise one, count its strong cycles
	task automatic turn_on(input logic hs, input logic [15:0] t, input logic u);
		{cmd_hs, cmd_ls, strong_drive_timer, timer_use_cfg} = {2'h0, t, u};
		tick(1);
		{cmd_hs, cmd_ls} = {hs, !hs};
		k = 0;
		repeat (40)
		begin
			tick(1);
			k += int'(hs ? drv_hs.strong_src : drv_ls.strong_src);
			if (hs && drv_hs.strong_src) chk(drv_ls.strong_pd, 1);
		end
		chk(k, (u && t != 0) ? t : 8);
	endtask : turn_on
	// Main sequence
	initial
	begin
		{rstn, cmd_hs, cmd_ls, fault_clear, timer_use_cfg, cmp_cfg_sel_serial, short_hs, oc_hs} = 8'h00;
		{strong_drive_timer, cmp_cfg_serial, cmp_cfg_pins} = 32'h00000000;
		seed = 32'h00000028;
		tick(6);
		rstn = 1'b1;
		for (i = 0; i < 6; i++)
		begin
			seed = xs(seed);
			// Timers shorter than gate rise plus sync would fault: use 0 or 8 to 15
			turn_on(i[0] == 1'b0, seed[3] ? 16'(seed[3:0]) : 16'h0000, seed[4]);
			chk(i[0] ? drv_ls.hold_src : drv_hs.hold_src, 1);
		end
		short_hs = 1'b1;
		turn_on(1'b1, 16'h0000, 1'b0);
		chk({gate_fault_hs, drv_hs.hold_src, drv_hs.weak_pd}, 3'h5);
		tick(20);
		chk(gate_fault_hs, 1);
		{short_hs, fault_clear} = 2'h1;
		tick(4);
		fault_clear = 1'b0;
		chk(gate_fault_hs, 0);
		tick(30);
		oc_hs = 1'b1;
		tick(8);
		chk(overcurrent_hs, 1);
		for (i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			{cmp_cfg_sel_serial, cmp_cfg_pins, cmp_cfg_serial} = seed[16:0];
			tick(4);
			chk(cmp_cfg, cmp_cfg_sel_serial ? cmp_cfg_serial : cmp_cfg_pins);
		end
		chk({gate_fault_ls, overcurrent_ls}, 2'h0);
		end_of_test();
	end
	// Watchdog
	initial
	begin
		#20000;
		n_mismatch++;
		end_of_test();
	end
endmodule : hbgd_sequencer_test
`default_nettype wire
